/* File: design/ztsp_pkg.sv */
// Package for the zero turnaround SRAM port: widths, memory depth, carrier types.
// Assumes a single clock domain shared with the memory controller.
package ztsp_pkg;
    localparam int ZTSP_DW    = 36;
    localparam int ZTSP_AW    = 17;
    localparam int ZTSP_BW    = 4;
    localparam int ZTSP_BYTE  = 9;
    localparam int ZTSP_DEPTH = 131072;

    // Control pins sampled at each edge
    typedef struct packed {
        logic                 clk_gate_n;
        logic                 adv_or_load;
        logic                 chip_sel1_n;
        logic                 chip_sel2;
        logic                 chip_sel3_n;
        logic                 rd_wr_sel;
        logic [ZTSP_BW-1:0]   byte_wr_n;
        logic [ZTSP_AW-1:0]   addr;
    } ztsp_ctl_t;

    // Operation held between its load edge and its data edge
    typedef enum logic [1:0] {ZTSP_IDLE, ZTSP_RD, ZTSP_WR} ztsp_op_t;
endpackage

/* File: design/ztsp_port.sv */
// Zero turnaround pipelined SRAM port with clock gate and composite select.
// Assumes the controller shares clk; pins are driven synchronously by it.
// Behaviour
// - Gated edge (clk_gate_n high) ignores all inputs but srst and freezes all state unless srst is high.
// - While edges are gated, the read word stays on the data bus.
// - A loaded read drives its word after the next enabled edge.
// - A read load is accepted each enabled edge while old read drives.
// - A write load is accepted each enabled edge while old write captures.
// - Deselect after read load still drives the pending read data.
// - Deselect after write load still captures the pending write data.
// - After deselect or non-read load, data bus is high impedance.
// - Select active only for sel1_n low, sel3_n low, sel2 high.
// - Data outputs are high impedance from srst until a loaded read reaches its data edge.
`timescale 1ns/1ns
module ztsp_port
    import ztsp_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // Control pins
    input  wire ztsp_ctl_t           ctl,
    input  wire logic                out_en_n,
    // Data bus
    input  wire logic [ZTSP_DW-1:0]  dq_in,
    output logic      [ZTSP_DW-1:0]  dq_out,
    output logic                     dq_oe
);
    ztsp_op_t              op_r;
    logic [ZTSP_AW-1:0]    addr_r;
    logic [ZTSP_BW-1:0]    bw_r;
    logic [ZTSP_DW-1:0]    mem [ZTSP_DEPTH];
    logic [ZTSP_DW-1:0]    dq_out_r;
    logic                  dq_oe_r;

    // Decode of the sampled pins
    wire logic     edge_en  = ~ctl.clk_gate_n;
    wire logic     selected = ~ctl.chip_sel1_n & ~ctl.chip_sel3_n & ctl.chip_sel2;
    wire logic     load     = edge_en & ~ctl.adv_or_load & selected;
    wire ztsp_op_t op_nxt   = ~load ? ZTSP_IDLE : (ctl.rd_wr_sel ? ZTSP_RD : ZTSP_WR);
    wire logic     rd_now   = edge_en & (op_nxt == ZTSP_RD);
    wire logic     wr_due   = edge_en & (op_r == ZTSP_WR);

    // Pending operation; a gated edge keeps it unless srst is high, any enabled edge replaces it
    always_ff @(posedge clk) begin
        if (srst) begin
            op_r   <= ZTSP_IDLE;
            addr_r <= '0;
            bw_r   <= '1;
        end else if (edge_en) begin
            op_r   <= (ctl.adv_or_load & selected) ? ZTSP_IDLE : op_nxt;
            addr_r <= ctl.addr;
            bw_r   <= ctl.byte_wr_n;
        end
    end

    // Write capture on the data edge, also when deselected then
    always_ff @(posedge clk) begin
        if (wr_due) begin
            for (int b = 0; b < ZTSP_BW; b++) begin
                if (!bw_r[b])
                    mem[addr_r][b*ZTSP_BYTE +: ZTSP_BYTE] <= dq_in[b*ZTSP_BYTE +: ZTSP_BYTE];
            end
        end
    end

    // Read word registered so it appears right after the load's next enabled edge
    always_ff @(posedge clk) begin
        if (srst) begin
            dq_oe_r  <= 1'b0;
            dq_out_r <= '0;
        end else if (edge_en) begin
            dq_oe_r  <= (op_r == ZTSP_RD);
            if (op_r == ZTSP_RD)
                dq_out_r <= mem[addr_r];
        end
    end

    // Output enable pin gates the drive; data comes from flip-flops
    assign dq_out = dq_out_r;
    assign dq_oe  = dq_oe_r & ~out_en_n;

    // Named steps that the properties below are built from.
    // A read or write is taken at one enabled edge; its data moves at the next one.
    sequence s_rd_load;
        edge_en && load && ctl.rd_wr_sel;
    endsequence

    sequence s_wr_load;
        edge_en && load && !ctl.rd_wr_sel;
    endsequence

    sequence s_rd_data;
        edge_en && op_r == ZTSP_RD;
    endsequence

    sequence s_wr_data;
        edge_en && op_r == ZTSP_WR;
    endsequence

    // Read data edge followed by a gated edge: the word must stay put
    sequence s_rd_then_gated;
        s_rd_data ##1 ctl.clk_gate_n;
    endsequence

    // Read load, two gated edges, then the enabled data edge
    sequence s_rd_gap;
        s_rd_load ##1 ctl.clk_gate_n [*2] ##1 !ctl.clk_gate_n;
    endsequence

    // A read load leaves a pending read behind
    a_rd_loaded: assert property (@(posedge clk) disable iff (srst)
        s_rd_load |=> op_r == ZTSP_RD)
        else $error("read load not pending");

    // A write load leaves a pending write behind
    a_wr_loaded: assert property (@(posedge clk) disable iff (srst)
        s_wr_load |=> op_r == ZTSP_WR)
        else $error("write load not pending");

    // Address and lane enables are taken at the load edge
    a_load_addr: assert property (@(posedge clk) disable iff (srst)
        (edge_en && load) |=> addr_r == $past(ctl.addr) && bw_r == $past(ctl.byte_wr_n))
        else $error("load address not held");

    // Gated edge keeps address and lane enables
    a_gate_hold_addr: assert property (@(posedge clk) disable iff (srst)
        ctl.clk_gate_n |=> $stable(addr_r) && $stable(bw_r))
        else $error("address changed on gated edge");

    // Read word stays on the bus across a gated edge
    a_gated_hold_word: assert property (@(posedge clk) disable iff (srst)
        s_rd_then_gated |=> dq_oe_r && $stable(dq_out_r))
        else $error("read word not held while gated");

    // Read data edge registers the addressed word
    a_rd_word: assert property (@(posedge clk) disable iff (srst)
        s_rd_data |=> dq_out_r == $past(mem[addr_r]))
        else $error("read word wrong");

    // Gated edges between load and data edge do not lose the read
    a_rd_after_gap: assert property (@(posedge clk) disable iff (srst)
        s_rd_gap |=> dq_oe_r)
        else $error("read lost across gated edges");

    // Deselect in the data cycle of a read still drives the word
    a_desel_rd_drive: assert property (@(posedge clk) disable iff (srst)
        (edge_en && op_r == ZTSP_RD && !selected) |=> dq_oe_r)
        else $error("deselect dropped pending read");

    // Deselect in the data cycle of a write leaves the bus floating
    a_desel_wr_float: assert property (@(posedge clk) disable iff (srst)
        (edge_en && op_r == ZTSP_WR && !selected) |=> !dq_oe_r)
        else $error("deselected write drove bus");

    // Lane 0, when enabled, takes the bus value at the data edge
    a_wr_lane_low: assert property (@(posedge clk) disable iff (srst)
        (wr_due && !bw_r[0]) |=>
        mem[$past(addr_r)][ZTSP_BYTE-1:0] == $past(dq_in[ZTSP_BYTE-1:0]))
        else $error("enabled lane not written");

    // Lane 0, when disabled, keeps its old contents
    a_wr_lane_kept: assert property (@(posedge clk) disable iff (srst)
        (wr_due && bw_r[0]) |=>
        mem[$past(addr_r)][ZTSP_BYTE-1:0] == $past(mem[addr_r][ZTSP_BYTE-1:0]))
        else $error("disabled lane written");

    // Active-high select alone low blocks a load
    a_sel2_low: assert property (@(posedge clk) disable iff (srst)
        (edge_en && !ctl.adv_or_load && !ctl.chip_sel2) |=> op_r == ZTSP_IDLE)
        else $error("load taken with select low");

    // Advance without load starts nothing new
    a_adv_cancel: assert property (@(posedge clk) disable iff (srst)
        (edge_en && ctl.adv_or_load) |=> op_r == ZTSP_IDLE)
        else $error("advance started an operation");

    // Output enable pin high keeps the device off the bus
    a_oe_pin_gate: assert property (@(posedge clk) disable iff (srst)
        out_en_n |-> !dq_oe)
        else $error("drove bus with output enable high");

    // Back to back reads take the new address while the old word goes out
    a_back_rd_word: assert property (@(posedge clk) disable iff (srst)
        (rd_now && op_r == ZTSP_RD) |=>
        dq_out_r == $past(mem[addr_r]) && addr_r == $past(ctl.addr))
        else $error("back to back read word wrong");

    // Back to back writes take the new address during the old capture
    a_back_wr_addr: assert property (@(posedge clk) disable iff (srst)
        (s_wr_data ##0 (load && !ctl.rd_wr_sel)) |=> addr_r == $past(ctl.addr))
        else $error("back to back write address lost");

    // Freeze, drive, float and pending-operation checks on the pipeline state
    a_gate_freeze: assert property (@(posedge clk) disable iff (srst)
        ctl.clk_gate_n |=> $stable(op_r) && $stable(dq_oe_r) && $stable(dq_out_r))
        else $error("state changed on gated edge");
    a_read_drive: assert property (@(posedge clk) disable iff (srst)
        (edge_en && op_r == ZTSP_RD) |=> dq_oe_r)
        else $error("read data not driven");
    a_idle_float: assert property (@(posedge clk) disable iff (srst)
        (edge_en && op_r != ZTSP_RD) |=> !dq_oe_r)
        else $error("bus not floated");
    a_back_reads: assert property (@(posedge clk) disable iff (srst)
        (rd_now && op_r == ZTSP_RD) |=> (op_r == ZTSP_RD) && dq_oe_r)
        else $error("back to back read lost");
    a_back_writes: assert property (@(posedge clk) disable iff (srst)
        (edge_en && load && !ctl.rd_wr_sel && op_r == ZTSP_WR) |=> op_r == ZTSP_WR)
        else $error("back to back write lost");
    a_desel_idle: assert property (@(posedge clk) disable iff (srst)
        (edge_en && !selected && !ctl.adv_or_load) |=> op_r == ZTSP_IDLE)
        else $error("deselect loaded an operation");
    a_wr_no_drive: assert property (@(posedge clk) disable iff (srst)
        (edge_en && op_r == ZTSP_WR) |=> !dq_oe_r)
        else $error("drove bus during write data");
    a_reset_float: assert property (@(posedge clk)
        srst |=> !dq_oe_r && op_r == ZTSP_IDLE)
        else $error("outputs active after reset");
endmodule // ztsp_port

/* File: test/ztsp_ctl_model.sv */
// Controller data driver for the SRAM port bench.
// Assumes the bench flags when a write word is due.
`timescale 1ns/1ns
module ztsp_ctl_model
    import ztsp_pkg::*;
(
    // Bench side
    input  wire logic               drive,
    input  wire logic [ZTSP_DW-1:0] wdata,
    // Device side
    output logic      [ZTSP_DW-1:0] dq_in
);
    // Released bus shows the inverse word
    assign dq_in = drive ? wdata : ~wdata;
endmodule // ztsp_ctl_model

/* File: test/ztsp_port_tb.sv */
// Random bench for the SRAM port against a reference memory.
// Assumes one clock; the bench plays the controller.
`timescale 1ns/1ns
module ztsp_port_tb import ztsp_pkg::*;;
    logic        clk = 0, srst = 1, oe_n = 0, drive = 0, rv = 0, pw = 0, pr = 0, en;
    ztsp_ctl_t   ctl = '0;
    logic [35:0] dq_in, dq_out, wdata = '0;
    logic [35:0] mem [int];
    logic        dq_oe;
    logic [16:0] pa, ra;
    logic [3:0]  pb;
    logic [31:0] rs = 32'h93B9;
    int          fail_count = 0, total_checks = 0;
    always #10 clk = ~clk;
    ztsp_port ztsp_port_inst (.clk(clk), .srst(srst), .ctl(ctl), .out_en_n(oe_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    ztsp_ctl_model ztsp_ctl_model_inst (.drive(drive), .wdata(wdata), .dq_in(dq_in));
    // Xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Reference model steps only on enabled edges, and clears on any edge with srst high
    initial begin
        repeat (2) @(posedge clk);
        #2 srst = 0;
        chk(dq_oe, 0);
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            en = !ctl.clk_gate_n;
            if (en && pw) begin
                for (int b = 0; b < 4; b++)
                    if (!pb[b]) mem[pa][b*9 +: 9] = wdata[b*9 +: 9];
            end
            if (srst) begin
                rv = 0;
                pw = 0;
                pr = 0;
            end else if (en) begin
                rv = pr;
                ra = pa;
                pw = 0;
                pr = 0;
                if (!ctl.adv_or_load && !ctl.chip_sel1_n &&
                    ctl.chip_sel2 && !ctl.chip_sel3_n) begin
                    pa = ctl.addr;
                    pb = ctl.byte_wr_n;
                    pr = ctl.rd_wr_sel;
                    pw = !ctl.rd_wr_sel;
                end
            end
            #2;
            chk(dq_oe, rv & ~oe_n);
            if (rv && mem.exists(ra)) chk(dq_out, mem[ra]);
            rs = xs(rs);
            if (en) wdata = {rs, rs[7:4]};
            drive = pw;
            oe_n = &rs[20:18];
            ctl = '{&rs[1:0], &rs[4:2], &rs[7:5], ~&rs[10:8], &rs[13:11], rs[14], rs[24:21],
                {14'h0, rs[17:15]}};
            if (i < 8) ctl = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 17'(i)};
            // Second reset in mid-run, two edges long
            if (i == 1500) srst = 1;
            if (i == 1502) srst = 0;
        end
        end_sim;
    end
endmodule // ztsp_port_tb
